// ===== logic/brpf_cfg.svh
// Offsets, field positions, reset values and counts of the prefetch control
`ifndef BRPF_CFG_SVH
`define BRPF_CFG_SVH
`define BRPF_OFS_LINE 8'h0c
`define BRPF_OFS_CTRL 8'h44
`define BRPF_OFS_STAT 8'h48
`define BRPF_LINE_RST 8'h00
`define BRPF_CTRL_RST 8'h06
`define BRPF_CTRL_UP_DIS 0
`define BRPF_CTRL_DN_LINE 1
`define BRPF_CTRL_UP_LINE 2
`define BRPF_CTRL_DN_MPC_LO 4
`define BRPF_CTRL_UP_MPC_LO 6
`define BRPF_MIN_DW 12'h010
`define BRPF_PAGE_DW 12'h400
`define BRPF_ALIGN_DW 12'h010
`define BRPF_POST_DEPTH 3
`endif

// ===== logic/brpf_ctrl.sv
// Read prefetch control for the delayed read path of a bus bridge
`timescale 1ns/1ps
`include "brpf_cfg.svh"

// Functional notes
// - I/O and configuration reads are never prefetched, one Dword only.
// - Non-prefetchable read fetches one Dword with original byte enables.
// - Memory read line and multiple always prefetch, both directions.
// - Plain memory read prefetches by range downstream, by disable upstream.
// - Prefetching may assert all byte enables on the destination bus.
// - Unconsumed prefetched data is dropped when the initiator ends.
// - Count is max prefetch lines times line length plus boundary count.
// - In flow-through, prefetch until end, full FIFO, 4K page, disconnect.
// - Max prefetch below line length limits to first line boundary.
// - Computed prefetch count is never below 16 Dwords.
// - With an empty read buffer, prefetch may exceed the count; here fifo_empty_i is unused and the count holds.
// - Control bits 2 and 1 cleared enable the max prefetch fields.
// - A single Dword read is never prefetched.
// - Single pending request in flow-through ignores max prefetch count.
// - At a boundary stop prefetch, disconnect with the last Dword.
// - Flow-through prefetches to the 4 kB boundary or initiator end.
// - Read and read line stop at line or 16-Dword boundary.
// - Read multiple stops at second line boundary or queue full.
// - Prefetch is limited by free buffer space and boundaries.
// - First phase uses captured enables, later phases all enabled.
// - At most three queued reads per direction, duplicates not posted.
// - Flow-through starts when initiator takes data mid target read.
module brpf_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic post_req_i,
    input wire brpf_pkg::brpf_post_t post_i,
    output logic post_ok_o,
    input wire logic retire_i,
    input wire brpf_pkg::brpf_post_t retire_data_i,
    input wire logic start_i,
    input wire brpf_pkg::brpf_req_t req_i,
    output logic busy_o,
    input wire logic single_pending_i,
    output logic tgt_req_o,
    output logic [3:0] tgt_be_n_o,
    output logic tgt_last_o,
    input wire logic tgt_ack_i,
    input wire logic tgt_disc_i,
    input wire logic fifo_full_i,
    input wire logic fifo_empty_i,
    input wire logic init_take_i,
    input wire logic init_end_i,
    output logic init_disc_o,
    output logic discard_o,
    output logic flow_o
);
    import brpf_pkg::*;

    localparam int NPOST = 2 * `BRPF_POST_DEPTH;

    // Dwords from an address up to the next boundary of a power-of-two size
    function automatic logic [11:0] to_bound(input logic [9:0] adw,
                                             input logic [11:0] size);
        logic [11:0] off;
        off = {2'b00, adw} & (size - 12'h001);
        to_bound = size - off;
    endfunction : to_bound

    function automatic logic [11:0] min12(input logic [11:0] a,
                                          input logic [11:0] b);
        min12 = (a < b) ? a : b;
    endfunction : min12

    logic [7:0] line_len;
    logic [7:0] ctrl;
    brpf_state_t state;
    brpf_state_t next_state;
    brpf_req_t cur;
    logic pf;
    logic flow;
    logic [11:0] limit;
    logic [11:0] fetched;
    logic [11:0] delivered;
    logic tgt_over;
    logic [NPOST-1:0] pv;
    brpf_post_t pe [NPOST];

    // Register bus decode; every access is answered one cycle later
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_line = bus_req & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == `BRPF_OFS_LINE);
    wire wr_ctrl = bus_req & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == `BRPF_OFS_CTRL);
    wire [31:0] stat_word = {flow, state, 16'h0000, fetched};
    wire [31:0] rd_word = (wb_adr_i == `BRPF_OFS_LINE) ? {24'h0, line_len} :
                          (wb_adr_i == `BRPF_OFS_CTRL) ? {24'h0, ctrl} :
                          (wb_adr_i == `BRPF_OFS_STAT) ? stat_word : 32'h0;

    // Request classification
    wire is_mrm = req_i.cmd == BRPF_CMD_MEM_RD_MULT;
    wire is_mrl = req_i.cmd == BRPF_CMD_MEM_RD_LINE;
    wire is_mr = req_i.cmd == BRPF_CMD_MEM_RD;
    wire mr_pf = req_i.upstream ? ~ctrl[`BRPF_CTRL_UP_DIS]
                                : req_i.in_pf_range;
    // Only memory reads prefetch; I/O and config fall through as one Dword
    wire req_pf = (is_mrm | is_mrl | (is_mr & mr_pf))
                  & ~req_i.single_dw;

    // Boundary arithmetic on the starting Dword address
    wire [9:0] adw = req_i.addr[11:2];
    wire [11:0] len12 = {4'h0, line_len};
    wire len_ok = (line_len == 8'h01) | (line_len == 8'h02)
                  | (line_len == 8'h04) | (line_len == 8'h08);
    wire [11:0] to_page = to_bound(adw, `BRPF_PAGE_DW);
    wire [11:0] line_boundary_dword_count = len_ok ? to_bound(adw, len12)
        : to_bound(adw, `BRPF_ALIGN_DW);
    // Read multiple with an odd line size runs to the 4 kB page boundary unless the queue fills first
    wire [11:0] tbl_cnt = ~is_mrm ? line_boundary_dword_count
        : len_ok ? line_boundary_dword_count + len12
        : to_page;

    // Max prefetch lines are live only while the line-prefetch bit is clear
    wire line_only = req_i.upstream ? ctrl[`BRPF_CTRL_UP_LINE]
                                    : ctrl[`BRPF_CTRL_DN_LINE];
    wire [1:0] max_prefetch_lines = req_i.upstream
        ? ctrl[`BRPF_CTRL_UP_MPC_LO +: 2]
        : ctrl[`BRPF_CTRL_DN_MPC_LO +: 2];
    // Both operands widened first so the product keeps its upper bits
    wire [11:0] mpc_prod = {10'h000, max_prefetch_lines} * len12;
    wire [11:0] mpc_sum = ({6'h00, max_prefetch_lines} < {4'h0, line_len})
        ? line_boundary_dword_count
        : mpc_prod + line_boundary_dword_count;
    wire [11:0] prefetch_dword_count = (mpc_sum < `BRPF_MIN_DW)
        ? `BRPF_MIN_DW : mpc_sum;
    wire [11:0] pf_cnt = line_only ? tbl_cnt : prefetch_dword_count;
    wire [11:0] new_limit = req_pf ? min12(pf_cnt, to_page) : 12'h001;

    // Stop conditions on the target side
    wire [11:0] cur_page = to_bound(cur.addr[11:2], `BRPF_PAGE_DW);
    wire [11:0] eff_limit = flow ? cur_page : limit;
    wire last_phase = (fetched + 12'h001 >= eff_limit);
    wire tgt_stop = tgt_ack_i & (last_phase | fifo_full_i)
                    | tgt_disc_i | init_end_i;
    wire take_ok = init_take_i & (delivered != fetched);
    wire go_flow = pf & (state == BRPF_FETCH) & take_ok
                   & ~last_phase & single_pending_i;

    // Posting table: a duplicate or a full direction is refused
    logic [NPOST-1:0] hit;
    logic [NPOST-1:0] rhit;
    logic [NPOST-1:0] free;
    logic [2:0] used;
    always_comb begin
        used = 3'h0;
        for (int i = 0; i < NPOST; i++) begin
            hit[i] = pv[i] & (pe[i] == post_i);
            rhit[i] = pv[i] & (pe[i] == retire_data_i);
            free[i] = ~pv[i] & ((i >= `BRPF_POST_DEPTH) == post_i.upstream);
            if (pv[i] && pe[i].upstream == post_i.upstream) begin
                used = used + 3'h1;
            end
        end
    end
    assign post_ok_o = post_req_i & ~|hit
                       & (used < 3'(`BRPF_POST_DEPTH));

    // Lowest free slot of the request's direction
    logic [NPOST-1:0] pick;
    always_comb begin
        pick = '0;
        for (int i = NPOST - 1; i >= 0; i--) begin
            if (free[i]) begin
                pick = '0;
                pick[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pv <= '0;
        end else begin
            pv <= (pv & ~(retire_i ? rhit : '0))
                  | (post_ok_o ? pick : '0);
        end
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NPOST; i++) begin
            if (post_ok_o && pick[i]) begin
                pe[i] <= post_i;
            end
        end
    end

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            BRPF_IDLE: begin
                if (start_i) begin
                    next_state = BRPF_FETCH;
                end
            end
            BRPF_FETCH: begin
                if (init_end_i) begin
                    next_state = BRPF_IDLE;
                end else if (tgt_stop) begin
                    next_state = BRPF_DRAIN;
                end
            end
            BRPF_DRAIN: begin
                if (init_end_i || (take_ok && delivered + 12'h001 == fetched))
                begin
                    next_state = BRPF_IDLE;
                end
            end
            default: next_state = BRPF_IDLE;
        endcase
    end

    // Register bus and configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            line_len <= `BRPF_LINE_RST;
            ctrl <= `BRPF_CTRL_RST;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_word : 32'h0;
            if (wr_line) begin
                line_len <= wb_dat_i[7:0];
            end
            if (wr_ctrl) begin
                ctrl <= wb_dat_i[7:0];
            end
        end
    end

    // Transaction state; counters restart with every new request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= BRPF_IDLE;
            cur <= '0;
            pf <= 1'b0;
            flow <= 1'b0;
            limit <= 12'h000;
            fetched <= 12'h000;
            delivered <= 12'h000;
            tgt_over <= 1'b0;
            discard_o <= 1'b0;
        end else begin
            state <= next_state;
            discard_o <= (state != BRPF_IDLE) & init_end_i
                         & (delivered != fetched | ~tgt_over);
            if (state == BRPF_IDLE && start_i) begin
                cur <= req_i;
                pf <= req_pf;
                limit <= new_limit;
                fetched <= 12'h000;
                delivered <= 12'h000;
                flow <= 1'b0;
                tgt_over <= 1'b0;
            end else begin
                if (state == BRPF_FETCH && tgt_ack_i) begin
                    fetched <= fetched + 12'h001;
                end
                if (take_ok) begin
                    delivered <= delivered + 12'h001;
                end
                if (go_flow) begin
                    flow <= 1'b1;
                end
                if (state == BRPF_FETCH && tgt_stop) begin
                    tgt_over <= 1'b1;
                end
                if (next_state == BRPF_IDLE) begin
                    flow <= 1'b0;
                end
            end
        end
    end

    // Target side: first phase keeps the captured enables, later all on
    assign tgt_req_o = (state == BRPF_FETCH) & ~init_end_i;
    assign tgt_be_n_o = (fetched == 12'h000 || !pf) ? cur.be_n
                        : 4'h0;
    assign tgt_last_o = tgt_req_o & (last_phase | fifo_full_i);
    // Disconnect rides on the final Dword once fetching is over
    assign init_disc_o = take_ok & (state == BRPF_DRAIN)
                         & (delivered + 12'h001 == fetched);
    assign busy_o = state != BRPF_IDLE;
    assign flow_o = flow;
    // A stalled initiator sees an empty buffer; nothing to do but wait
    wire unused_ok = fifo_empty_i;
endmodule : brpf_ctrl

// ===== logic/brpf_pkg.sv
// Types shared by the read prefetch control block
package brpf_pkg;
    typedef enum logic [3:0] {
        BRPF_CMD_IO_RD = 4'h2,
        BRPF_CMD_MEM_RD = 4'h6,
        BRPF_CMD_CFG_RD = 4'ha,
        BRPF_CMD_MEM_RD_MULT = 4'hc,
        BRPF_CMD_MEM_RD_LINE = 4'he
    } brpf_cmd_t;

    typedef struct packed {
        logic [31:0] addr;
        brpf_cmd_t cmd;
        logic [3:0] be_n;
        logic upstream;
        logic single_dw;
        logic in_pf_range;
    } brpf_req_t;

    typedef struct packed {
        logic [31:0] addr;
        brpf_cmd_t cmd;
        logic upstream;
    } brpf_post_t;

    typedef enum logic [2:0] {
        BRPF_IDLE = 3'b001,
        BRPF_FETCH = 3'b010,
        BRPF_DRAIN = 3'b100
    } brpf_state_t;
endpackage : brpf_pkg

// ===== sim/brpf_ctrl_assertions.sv
// Concurrent checks on the read prefetch control ports
`timescale 1ns/1ps
module brpf_ctrl_chk
    import brpf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic start_i,
    input wire brpf_pkg::brpf_req_t req_i,
    input wire logic busy_o,
    input wire logic tgt_req_o,
    input wire logic [3:0] tgt_be_n_o,
    input wire logic tgt_last_o,
    input wire logic tgt_ack_i,
    input wire logic init_take_i,
    input wire logic init_end_i,
    input wire logic init_disc_o,
    input wire logic discard_o
);
    // All checks live in the single clock domain
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held too long");
    a_ack_next_cycle: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack missing");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data without ack");
    a_start_fetch: assert property (start_i && !busy_o |=> tgt_req_o && busy_o)
        else $error("read not launched");
    a_nonpf_one_dw: assert property (start_i && !busy_o &&
        (req_i.cmd == BRPF_CMD_IO_RD || req_i.cmd == BRPF_CMD_CFG_RD)
        |=> tgt_last_o && tgt_be_n_o == $past(req_i.be_n))
        else $error("non-prefetch read not single");
    a_single_no_pf: assert property
        (start_i && !busy_o && req_i.single_dw |=> tgt_last_o)
        else $error("single read prefetched");
    a_later_be_all: assert property
        (tgt_req_o && $past(tgt_req_o) && $past(tgt_ack_i) |-> tgt_be_n_o == 4'h0)
        else $error("later phase enables not all on");
    a_disc_with_take: assert property (init_disc_o |-> init_take_i)
        else $error("disconnect without data");
    a_discard_end: assert property (discard_o |-> $past(init_end_i))
        else $error("discard without initiator end");
endmodule : brpf_ctrl_chk

bind brpf_ctrl brpf_ctrl_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .start_i, .req_i, .busy_o, .tgt_req_o, .tgt_be_n_o,
    .tgt_last_o, .tgt_ack_i, .init_take_i, .init_end_i, .init_disc_o,
    .discard_o);

// ===== sim/brpf_ctrl_tb.sv
// Self-checking bench for the read prefetch control
`timescale 1ns/1ps
`include "brpf_cfg.svh"
module brpf_ctrl_tb;
    import brpf_pkg::*;
    typedef struct packed {
        brpf_cmd_t cmd;
        logic [2:0] f;
        logic [7:0] ctl, line, off;
        logic [3:0] be_n;
        logic [11:0] n;
    } brpf_row_t;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, post_req_i;
    logic [7:0] wb_adr_i;
    logic [3:0] tgt_be_n_o, first_be;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    brpf_post_t post_i, retire_data_i;
    brpf_req_t req_i;
    logic post_ok_o, retire_i, start_i, busy_o, single_pending_i, tgt_req_o;
    logic tgt_last_o, tgt_ack_i, tgt_disc_i, init_take_i, init_end_i;
    logic init_disc_o, discard_o, flow_o, slow, rest_bad, last_seen, full;
    logic [11:0] ndw;
    int fails = 0, checks = 0, ticks = 0, i, k;
    // Flags are upstream, single Dword, in prefetch range
    brpf_row_t rows [10] = '{
        '{BRPF_CMD_IO_RD, 3'h0, 8'h06, 8'h08, 8'h00, 4'h5, 12'h1},
        '{BRPF_CMD_CFG_RD, 3'h0, 8'h06, 8'h08, 8'h00, 4'h9, 12'h1},
        '{BRPF_CMD_MEM_RD, 3'h0, 8'h06, 8'h08, 8'h00, 4'ha, 12'h1},
        '{BRPF_CMD_MEM_RD, 3'h1, 8'h06, 8'h08, 8'h00, 4'h3, 12'h8},
        '{BRPF_CMD_MEM_RD, 3'h4, 8'h06, 8'h08, 8'h00, 4'h3, 12'h8},
        '{BRPF_CMD_MEM_RD, 3'h4, 8'h07, 8'h08, 8'h00, 4'h3, 12'h1},
        '{BRPF_CMD_MEM_RD_LINE, 3'h0, 8'h06, 8'h08, 8'h10, 4'hc, 12'h4},
        '{BRPF_CMD_MEM_RD_LINE, 3'h0, 8'h06, 8'h10, 8'h00, 4'h0, 12'h10},
        '{BRPF_CMD_MEM_RD_LINE, 3'h2, 8'h06, 8'h08, 8'h00, 4'he, 12'h1},
        '{BRPF_CMD_MEM_RD_MULT, 3'h4, 8'h06, 8'h04, 8'h00, 4'h0, 12'h8}
    };

    brpf_ctrl DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .post_req_i, .post_i,
        .post_ok_o, .retire_i, .retire_data_i, .start_i, .req_i, .busy_o,
        .single_pending_i, .tgt_req_o, .tgt_be_n_o, .tgt_last_o, .tgt_ack_i,
        .tgt_disc_i, .fifo_full_i(full), .fifo_empty_i(1'h0), .init_take_i,
        .init_end_i, .init_disc_o, .discard_o, .flow_o);
    brpf_tgt_model u_tgt (.clk_i, .rst_i, .slow_i(slow), .start_i, .tgt_req_o,
        .tgt_be_n_o, .tgt_last_o, .tgt_ack_i, .tgt_disc_i, .ndw_o(ndw),
        .first_be_o(first_be), .rest_bad_o(rest_bad), .last_seen_o(last_seen));

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string s, input logic [31:0] e, v);
        checks++;
        if (v !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", s, e, v);
        end
    endtask : chk

    // One classic bus cycle; held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'h1 && k < 20);
        q = wb_dat_o;
        chk("ack", 1, wb_ack_o);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk_i);
    endtask : wb

    // Runs one read, then drains it through the initiator side
    task automatic rd(input brpf_row_t r);
        wb(1'h1, `BRPF_OFS_LINE, {24'h0, r.line});
        wb(1'h1, `BRPF_OFS_CTRL, {24'h0, r.ctl});
        start_i <= 1'h1;
        req_i <= '{{24'h10, r.off}, r.cmd, r.be_n, r.f[2], r.f[1], r.f[0]};
        @(posedge clk_i);
        start_i <= 1'h0;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (tgt_req_o === 1'h1 && k < 100);
        chk("count", r.n, ndw);
        chk("first be", r.be_n, first_be);
        chk("later be", 0, rest_bad);
        chk("last", 1, last_seen);
        for (i = 0; i < r.n; i++) begin
            init_take_i <= 1'h1;
            #1 chk("disc", i == r.n - 1, init_disc_o);
            @(posedge clk_i);
        end
        init_take_i <= 1'h0;
        @(posedge clk_i);
        #1 chk("idle", 0, busy_o);
        @(posedge clk_i);
    endtask : rd

    task automatic post(input logic [7:0] a, input logic u, input logic e);
        post_req_i <= 1'h1;
        post_i <= '{{24'h10, a}, BRPF_CMD_MEM_RD, u};
        #1 chk("post ok", e, post_ok_o);
        @(posedge clk_i);
    endtask : post

    // Free-running bench clock
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    // Cuts a hung run short
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 20000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        {rst_i, slow, single_pending_i, full} = 4'h8;
        {wb_cyc_i, wb_stb_i, wb_we_i, post_req_i, retire_i} = 5'h0;
        {start_i, init_take_i, init_end_i} = 3'h0;
        {wb_adr_i, wb_dat_i, post_i, retire_data_i, req_i} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        #1 chk("reset busy", 0, busy_o);
        @(posedge clk_i);
        wb(1'h0, `BRPF_OFS_LINE, 0);
        chk("line reset", `BRPF_LINE_RST, q);
        wb(1'h0, `BRPF_OFS_CTRL, 0);
        chk("ctrl reset", `BRPF_CTRL_RST, q);
        wb(1'h1, `BRPF_OFS_CTRL, 32'h30);
        wb(1'h0, `BRPF_OFS_CTRL, 0);
        chk("ctrl rw", 32'h30, q);
        wb(1'h0, 8'h20, 0);
        chk("unmapped", 0, q);
        foreach (rows[j]) rd(rows[j]);
        // A full read FIFO ends a line read after its first Dword
        full <= 1'h1;
        rd('{BRPF_CMD_MEM_RD_LINE, 3'h0, 8'h06, 8'h08, 8'h00, 4'h3, 12'h1});
        full <= 1'h0;
        // Duplicate and fourth entry refused, other direction free
        post(8'h00, 1'h0, 1'h1);
        post(8'h00, 1'h0, 1'h0);
        post(8'h04, 1'h0, 1'h1);
        post(8'h08, 1'h0, 1'h1);
        post(8'h0c, 1'h0, 1'h0);
        post(8'h00, 1'h1, 1'h1);
        post_req_i <= 1'h0;
        retire_i <= 1'h1;
        retire_data_i <= '{32'h1000, BRPF_CMD_MEM_RD, 1'h0};
        @(posedge clk_i);
        retire_i <= 1'h0;
        post(8'h0c, 1'h0, 1'h1);
        post_req_i <= 1'h0;
        // Early take on a slow target, then initiator ends
        {slow, single_pending_i} <= 2'h3;
        start_i <= 1'h1;
        req_i <= '{32'h1000, BRPF_CMD_MEM_RD_LINE, 4'h0, 1'h0, 1'h0, 1'h0};
        @(posedge clk_i);
        start_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        init_take_i <= 1'h1;
        @(posedge clk_i);
        init_take_i <= 1'h0;
        init_end_i <= 1'h1;
        #1 chk("flow", 1, flow_o);
        @(posedge clk_i);
        init_end_i <= 1'h0;
        #1 chk("discard", 1, discard_o);
        repeat (3) @(posedge clk_i);
        chk("end idle", 0, busy_o);
        give_verdict();
    end
endmodule : brpf_ctrl_tb

// ===== sim/brpf_tgt_model.sv
// Far-side target model that answers reads promptly or slowly
`timescale 1ns/1ps
module brpf_tgt_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic start_i,
    input wire logic tgt_req_o,
    input wire logic [3:0] tgt_be_n_o,
    input wire logic tgt_last_o,
    output logic tgt_ack_i,
    output logic tgt_disc_i,
    output logic [11:0] ndw_o,
    output logic [3:0] first_be_o,
    output logic rest_bad_o,
    output logic last_seen_o
);
    logic odd;
    // Slow mode answers every other cycle to stretch bursts
    assign tgt_ack_i = tgt_req_o && !(slow_i && odd);
    assign tgt_disc_i = 1'h0;
    // Records count, enables and end marker of each burst
    always_ff @(posedge clk_i) begin
        if (rst_i || start_i) begin
            odd <= 1'h0;
            ndw_o <= 12'h0;
            first_be_o <= 4'hf;
            rest_bad_o <= 1'h0;
            last_seen_o <= 1'h0;
        end else begin
            odd <= !odd;
            if (tgt_ack_i) begin
                ndw_o <= ndw_o + 12'h1;
                if (ndw_o == 12'h0) first_be_o <= tgt_be_n_o;
                else if (tgt_be_n_o != 4'h0) rest_bad_o <= 1'h1;
                if (tgt_last_o) last_seen_o <= 1'h1;
            end
        end
    end
endmodule : brpf_tgt_model
